// >>> hw/scs_defines.vh
// Constants of the sensor command interpreter: codes, offsets, resets.
// Assumes a byte-framed link in front and firmware on classic Wishbone.
// Summary of operation
// - Tracking request returns six tracking bytes
// - Get-mode returns the current mode byte
// - Mode codes; unknown codes behave as suspend
// - Set-mode restarts measurement, loads its parameter as mode
// - Set-mode drives sample alert low
// - Mode resets to suspend code
// - Humidity starts at fifty percent
// - Results request drives sample alert low, unless a sample lands in the same cycle
// - Sample counter restarts at zero, counts samples
// - Result fields saturate at all ones
// - Results length follows current mode
// - Indoor modes send five listed fields
// - Public building mode sends two fields
// - Direction bits zero and one, others ignored
// - Pins three and four always inputs
// - Pin read gives four levels, upper zeros
// - Pin set drives selected pins high
// - Pin clear drives selected pins low
// - No pulls on user pins
// - Frame sum of code, params, checksum 0xFF
// - Responses start with status byte
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH
`define SCS_CMD_TRACK     8'h01
`define SCS_CMD_GET_MODE  8'h10
`define SCS_CMD_SET_MODE  8'h11
`define SCS_CMD_SET_HUM   8'h12
`define SCS_CMD_RESULTS   8'h18
`define SCS_CMD_PIN_DIR   8'h20
`define SCS_CMD_PIN_GET   8'h21
`define SCS_CMD_PIN_SET   8'h22
`define SCS_CMD_PIN_CLR   8'h23
`define SCS_MODE_SUSPEND  8'h00
`define SCS_MODE_IAQ      8'h01
`define SCS_MODE_ULP      8'h02
`define SCS_MODE_PUBLIC   8'h05
`define SCS_MODE_CLEAN    8'h80
`define SCS_HUM_RESET     8'h80
`define SCS_SUM_OK        8'hFF
`define SCS_ST_INVALID    7
`define SCS_ST_CSUM       6
`define SCS_LEN_IAQ       4'h8
`define SCS_LEN_PUBLIC    4'h4
`define SCS_LEN_TRACK     4'h6
`define SCS_ADR_CTRL      8'h00
`define SCS_ADR_QUAL      8'h04
`define SCS_ADR_VOC       8'h08
`define SCS_ADR_ETH       8'h0C
`define SCS_ADR_CO2       8'h10
`define SCS_ADR_REL       8'h14
`define SCS_ADR_TRK_LO    8'h18
`define SCS_ADR_TRK_HI    8'h1C
`define SCS_ADR_ERR       8'h20
`define SCS_ADR_STATUS    8'h24
`endif

// >>> hw/scs_command_set.v
// Sensor command interpreter: request decode, response build, user pins.
// Assumes a byte link front end (rx strobe, frame start, tx handshake)
// and measurement firmware writing results over classic Wishbone.
`timescale 1ns/1ns
`include "scs_defines.vh"
module scs_command_set (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        rx_start_i,
    input  wire        rx_valid_i,
    input  wire [7:0]  rx_data_i,
    input  wire        rx_err_i,
    output wire        tx_valid_o,
    input  wire        tx_ready_i,
    output reg  [7:0]  tx_data_o,
    output reg         sample_alert_o,
    input  wire        user_pin_one_i,
    output reg         user_pin_one_o,
    output reg         user_pin_one_oe_o,
    input  wire        user_pin_two_i,
    output reg         user_pin_two_o,
    output reg         user_pin_two_oe_o,
    input  wire        user_pin_three_i,
    input  wire        user_pin_four_i
);
    localparam [2:0] ST_CODE  = 3'd0;
    localparam [2:0] ST_PARAM = 3'd1;
    localparam [2:0] ST_CSUM  = 3'd2;
    localparam [2:0] ST_EXEC  = 3'd3;
    localparam [2:0] ST_SEND  = 3'd4;
    localparam [2:0] ST_DRAIN = 3'd5;

    reg [2:0]  state_reg;
    reg [7:0]  code_reg;
    reg [7:0]  param_reg;
    reg [7:0]  sum_reg;
    reg        need_reg;
    reg        frame_err_reg;
    reg [7:0]  mode_reg;
    reg [7:0]  hum_reg;
    reg [7:0]  count_reg;
    reg [1:0]  dir_reg;
    reg [1:0]  lvl_reg;
    reg [31:0] qual_reg;
    reg [31:0] voc_reg;
    reg [31:0] eth_reg;
    reg [31:0] co2_reg;
    reg [31:0] rel_reg;
    reg [47:0] track_reg;
    reg [3:0]  err_code_reg;
    reg [7:0]  resp_reg [0:8];
    reg [3:0]  resp_len_reg;
    reg [3:0]  idx_reg;
    reg [7:0]  tx_sum_reg;
    integer    i;

    // Parameter bytes a request carries
    function need_param;
        input [7:0] code;
        begin
            case (code)
                `SCS_CMD_SET_MODE, `SCS_CMD_SET_HUM, `SCS_CMD_PIN_DIR,
                `SCS_CMD_PIN_SET, `SCS_CMD_PIN_CLR: need_param = 1'b1;
                default: need_param = 1'b0;
            endcase
        end
    endfunction

    function known_code;
        input [7:0] code;
        begin
            case (code)
                `SCS_CMD_TRACK, `SCS_CMD_GET_MODE, `SCS_CMD_SET_MODE,
                `SCS_CMD_SET_HUM, `SCS_CMD_RESULTS, `SCS_CMD_PIN_DIR,
                `SCS_CMD_PIN_GET, `SCS_CMD_PIN_SET, `SCS_CMD_PIN_CLR:
                    known_code = 1'b1;
                default: known_code = 1'b0;
            endcase
        end
    endfunction

    function [7:0] sat8;
        input [31:0] v;
        begin
            sat8 = (|v[31:8]) ? 8'hFF : v[7:0];
        end
    endfunction

    function [15:0] sat16;
        input [31:0] v;
        begin
            sat16 = (|v[31:16]) ? 16'hFFFF : v[15:0];
        end
    endfunction

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr  = wb_req & wb_we_i & (&wb_sel_i);
    wire sample_pulse = wb_wr & (wb_adr_i == `SCS_ADR_CTRL) & wb_dat_i[0];
    wire [7:0] sum_next = sum_reg + rx_data_i;
    wire bad_sum = (sum_next != `SCS_SUM_OK);
    wire ok_exec = ~frame_err_reg & known_code(code_reg);
    wire [3:0] pin_levels = {user_pin_four_i, user_pin_three_i,
                             user_pin_two_i, user_pin_one_i};
    wire [15:0] voc16 = sat16(voc_reg);
    wire [15:0] eth16 = sat16(eth_reg);
    wire [15:0] co216 = sat16(co2_reg);
    wire is_iaq = (mode_reg == `SCS_MODE_IAQ) | (mode_reg == `SCS_MODE_ULP);
    wire is_pub = (mode_reg == `SCS_MODE_PUBLIC);
    wire exec_set_mode = (state_reg == ST_EXEC) & ok_exec & ~frame_err_reg
                         & (code_reg == `SCS_CMD_SET_MODE);
    wire exec_results  = (state_reg == ST_EXEC) & ok_exec
                         & (code_reg == `SCS_CMD_RESULTS);

    assign tx_valid_o = (state_reg == ST_SEND);

    // Request parser and response sequencer
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg     <= ST_CODE;
            code_reg      <= 8'h00;
            param_reg     <= 8'h00;
            sum_reg       <= 8'h00;
            need_reg      <= 1'b0;
            frame_err_reg <= 1'b0;
            resp_len_reg  <= 4'h0;
            idx_reg       <= 4'h0;
            tx_sum_reg    <= 8'h00;
            tx_data_o     <= 8'h00;
            for (i = 0; i < 9; i = i + 1)
                resp_reg[i] <= 8'h00;
        end else if (rx_start_i) begin
            // A new frame abandons any unread response
            state_reg     <= ST_CODE;
            sum_reg       <= 8'h00;
            frame_err_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_CODE: begin
                    if (rx_valid_i) begin
                        code_reg  <= rx_data_i;
                        sum_reg   <= sum_next;
                        need_reg  <= need_param(rx_data_i);
                        state_reg <= need_param(rx_data_i) ? ST_PARAM : ST_CSUM;
                    end
                    if (rx_err_i)
                        frame_err_reg <= 1'b1;
                end
                ST_PARAM: begin
                    if (rx_valid_i) begin
                        param_reg <= rx_data_i;
                        sum_reg   <= sum_next;
                        state_reg <= ST_CSUM;
                    end
                    if (rx_err_i)
                        frame_err_reg <= 1'b1;
                end
                ST_CSUM: begin
                    if (rx_valid_i) begin
                        state_reg <= ST_EXEC;
                        // Checksum failure blocks execution
                        if (bad_sum)
                            code_reg <= 8'hFF;
                        resp_reg[0] <= {~known_code(code_reg) & ~bad_sum | rx_err_i
                                        | frame_err_reg, bad_sum, 2'b00,
                                        err_code_reg};
                    end
                    if (rx_err_i)
                        frame_err_reg <= 1'b1;
                end
                ST_EXEC: begin
                    // Status byte must already stand when valid rises
                    tx_data_o    <= {resp_reg[0][7] | frame_err_reg, resp_reg[0][6:0]};
                    resp_len_reg <= 4'h1;
                    idx_reg      <= 4'h0;
                    tx_sum_reg   <= 8'h00;
                    state_reg    <= ST_SEND;
                    if (frame_err_reg)
                        resp_reg[0][`SCS_ST_INVALID] <= 1'b1;
                    if (ok_exec) begin
                        case (code_reg)
                            `SCS_CMD_TRACK: begin
                                resp_len_reg <= 4'h1 + `SCS_LEN_TRACK;
                                for (i = 0; i < 6; i = i + 1)
                                    resp_reg[i + 1] <= track_reg[47 - 8 * i -: 8];
                            end
                            `SCS_CMD_GET_MODE: begin
                                resp_len_reg <= 4'h2;
                                resp_reg[1]  <= mode_reg;
                            end
                            `SCS_CMD_PIN_GET: begin
                                resp_len_reg <= 4'h2;
                                resp_reg[1]  <= {4'h0, pin_levels};
                            end
                            `SCS_CMD_RESULTS: begin
                                if (is_iaq) begin
                                    resp_len_reg <= 4'h1 + `SCS_LEN_IAQ;
                                    resp_reg[1] <= sat8(qual_reg);
                                    resp_reg[2] <= voc16[15:8];
                                    resp_reg[3] <= voc16[7:0];
                                    resp_reg[4] <= eth16[15:8];
                                    resp_reg[5] <= eth16[7:0];
                                    resp_reg[6] <= co216[15:8];
                                    resp_reg[7] <= co216[7:0];
                                    resp_reg[8] <= sat8(rel_reg);
                                end else if (is_pub) begin
                                    resp_len_reg <= 4'h1 + `SCS_LEN_PUBLIC;
                                    resp_reg[1] <= voc16[15:8];
                                    resp_reg[2] <= voc16[7:0];
                                    resp_reg[3] <= eth16[15:8];
                                    resp_reg[4] <= eth16[7:0];
                                end
                            end
                            default: begin
                                resp_len_reg <= 4'h1;
                            end
                        endcase
                    end
                end
                ST_SEND: begin
                    // Payload bytes, then the closing checksum
                    if (idx_reg < resp_len_reg)
                        tx_data_o <= resp_reg[idx_reg];
                    else
                        tx_data_o <= ~tx_sum_reg;
                    if (tx_ready_i) begin
                        if (idx_reg == resp_len_reg) begin
                            state_reg <= ST_CODE;
                            sum_reg   <= 8'h00;
                        end else begin
                            idx_reg    <= idx_reg + 4'h1;
                            tx_sum_reg <= tx_sum_reg + resp_reg[idx_reg];
                            tx_data_o  <= (idx_reg + 4'h1 < resp_len_reg) ?
                                          resp_reg[idx_reg + 4'h1] :
                                          ~(tx_sum_reg + resp_reg[idx_reg]);
                        end
                    end
                end
                default: begin
                    state_reg <= ST_CODE;
                end
            endcase
        end
    end

    // Mode, humidity, sample counter, alert and user pins
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_reg          <= `SCS_MODE_SUSPEND;
            hum_reg           <= `SCS_HUM_RESET;
            count_reg         <= 8'h00;
            sample_alert_o    <= 1'b0;
            dir_reg           <= 2'b00;
            lvl_reg           <= 2'b00;
            user_pin_one_o    <= 1'b0;
            user_pin_one_oe_o <= 1'b0;
            user_pin_two_o    <= 1'b0;
            user_pin_two_oe_o <= 1'b0;
        end else begin
            if (exec_set_mode) begin
                mode_reg  <= param_reg;
                count_reg <= 8'h00;
            end else if (sample_pulse) begin
                count_reg <= count_reg + 8'h01;
            end
            // A fresh sample in the same cycle wins over the results clear, not over the set-mode clear
            if (sample_pulse & ~exec_set_mode)
                sample_alert_o <= 1'b1;
            else if (exec_set_mode | exec_results)
                sample_alert_o <= 1'b0;
            if ((state_reg == ST_EXEC) & ok_exec) begin
                case (code_reg)
                    `SCS_CMD_SET_HUM: hum_reg <= param_reg;
                    `SCS_CMD_PIN_DIR: dir_reg <= param_reg[1:0];
                    `SCS_CMD_PIN_SET: lvl_reg <= lvl_reg | param_reg[1:0];
                    `SCS_CMD_PIN_CLR: lvl_reg <= lvl_reg & ~param_reg[1:0];
                    default: lvl_reg <= lvl_reg;
                endcase
            end
            // Only pins one and two have drivers; no pulls on any pin
            user_pin_one_o    <= lvl_reg[0];
            user_pin_two_o    <= lvl_reg[1];
            user_pin_one_oe_o <= dir_reg[0];
            user_pin_two_oe_o <= dir_reg[1];
        end
    end

    // Wishbone slave: one wait state, unmapped reads give zero
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h0000_0000;
            qual_reg     <= 32'h0000_0000;
            voc_reg      <= 32'h0000_0000;
            eth_reg      <= 32'h0000_0000;
            co2_reg      <= 32'h0000_0000;
            rel_reg      <= 32'h0000_0000;
            track_reg    <= 48'h0000_0000_0000;
            err_code_reg <= 4'h0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_wr) begin
                case (wb_adr_i)
                    `SCS_ADR_QUAL:   qual_reg <= wb_dat_i;
                    `SCS_ADR_VOC:    voc_reg  <= wb_dat_i;
                    `SCS_ADR_ETH:    eth_reg  <= wb_dat_i;
                    `SCS_ADR_CO2:    co2_reg  <= wb_dat_i;
                    `SCS_ADR_REL:    rel_reg  <= wb_dat_i;
                    `SCS_ADR_TRK_LO: track_reg[31:0]  <= wb_dat_i;
                    `SCS_ADR_TRK_HI: track_reg[47:32] <= wb_dat_i[15:0];
                    `SCS_ADR_ERR:    err_code_reg <= wb_dat_i[3:0];
                    default:         err_code_reg <= err_code_reg;
                endcase
            end
            if (wb_req & ~wb_we_i) begin
                case (wb_adr_i)
                    `SCS_ADR_QUAL:   wb_dat_o <= qual_reg;
                    `SCS_ADR_VOC:    wb_dat_o <= voc_reg;
                    `SCS_ADR_ETH:    wb_dat_o <= eth_reg;
                    `SCS_ADR_CO2:    wb_dat_o <= co2_reg;
                    `SCS_ADR_REL:    wb_dat_o <= rel_reg;
                    `SCS_ADR_TRK_LO: wb_dat_o <= track_reg[31:0];
                    `SCS_ADR_TRK_HI: wb_dat_o <= {16'h0000, track_reg[47:32]};
                    `SCS_ADR_ERR:    wb_dat_o <= {28'h0000000, err_code_reg};
                    `SCS_ADR_STATUS: wb_dat_o <= {5'h00, dir_reg, sample_alert_o,
                                                  hum_reg, count_reg, mode_reg};
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // scs_command_set

// >>> tb/scs_command_set_assertions.sv
// Port timing checks of the sensor command interpreter.
// Bound to scs_command_set; sees its ports only.
`timescale 1ns/1ns
module scs_command_set_assertions (
    input wire       clk_i,
    input wire       nrst_i,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_we_i,
    input wire       wb_ack_o,
    input wire       rx_start_i,
    input wire       rx_valid_i,
    input wire       tx_valid_o,
    input wire       tx_ready_i,
    input wire [7:0] tx_data_o,
    input wire       sample_alert_o,
    input wire       user_pin_one_o,
    input wire       user_pin_one_oe_o,
    input wire       user_pin_two_o,
    input wire       user_pin_two_oe_o
);
    // Recent request bytes and bus writes; every side effect needs a cause
    reg [3:0] rx_reg;
    reg [2:0] wr_reg;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_reg <= 4'h0;
            wr_reg <= 3'h0;
        end else begin
            rx_reg <= {rx_reg[2:0], rx_valid_i};
            wr_reg <= {wr_reg[1:0], wb_cyc_i & wb_stb_i & wb_we_i};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_tx_holds: assert property (tx_valid_o && !tx_ready_i && !rx_start_i
        |=> tx_valid_o && $stable(tx_data_o)) else $error("offered byte not held");
    a_tx_after_req: assert property ($rose(tx_valid_o) |-> |rx_reg)
        else $error("response without request");
    a_alert_clear: assert property ($fell(sample_alert_o) |-> |rx_reg)
        else $error("alert dropped without request");
    a_alert_cause: assert property ($rose(sample_alert_o) |-> |wr_reg)
        else $error("alert raised without new sample");
    a_pin_one_cmd: assert property ($changed(user_pin_one_o) |-> |rx_reg)
        else $error("pin one changed without request");
    a_pin_two_cmd: assert property ($changed(user_pin_two_o) |-> |rx_reg)
        else $error("pin two changed without request");
    a_dir_cmd: assert property ($changed({user_pin_one_oe_o, user_pin_two_oe_o})
        |-> |rx_reg) else $error("direction changed without request");
endmodule // scs_command_set_assertions

bind scs_command_set scs_command_set_assertions i_chk (
    .clk_i             (clk_i),
    .nrst_i            (nrst_i),
    .wb_cyc_i          (wb_cyc_i),
    .wb_stb_i          (wb_stb_i),
    .wb_we_i           (wb_we_i),
    .wb_ack_o          (wb_ack_o),
    .rx_start_i        (rx_start_i),
    .rx_valid_i        (rx_valid_i),
    .tx_valid_o        (tx_valid_o),
    .tx_ready_i        (tx_ready_i),
    .tx_data_o         (tx_data_o),
    .sample_alert_o    (sample_alert_o),
    .user_pin_one_o    (user_pin_one_o),
    .user_pin_one_oe_o (user_pin_one_oe_o),
    .user_pin_two_o    (user_pin_two_o),
    .user_pin_two_oe_o (user_pin_two_oe_o)
);

// >>> tb/scs_host_model.sv
// Host side of the byte link: frames requests, collects responses.
// Assumes the interpreter's rx strobe and tx valid/ready handshake.
`timescale 1ns/1ns
module scs_host_model (
    input  wire        clk_i,
    output logic       rx_start_o = 1'b0,
    output logic       rx_valid_o = 1'b0,
    output logic [7:0] rx_data_o  = 8'hA5,
    output logic       rx_err_o   = 1'b0,
    output logic       tx_ready_o = 1'b0,
    input  wire        tx_valid_i,
    input  wire  [7:0] tx_data_i
);
    logic [7:0] rsp[$];
    task automatic put(input logic [7:0] b, input logic e = 1'b0);
        @(posedge clk_i);
        rx_start_o <= 1'b0;
        rx_valid_o <= 1'b1;
        rx_data_o  <= b;
        rx_err_o   <= e;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] p = 8'h00,
                       input bit bad = 1'b0, input int slow = 0,
                       input bit err = 1'b0);
        logic [7:0] s;
        int         n;
        s = 8'hFF - c - bad;
        rsp.delete();
        @(posedge clk_i);
        rx_start_o <= 1'b1;
        // A link error flagged with the code byte spoils the whole frame
        put(c, err);
        if (c inside {8'h11, 8'h12, 8'h20, 8'h22, 8'h23}) begin
            s = s - p;
            put(p);
        end
        put(s);
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        // Idle data never repeats the last byte
        rx_data_o  <= ~s;
        for (n = 0; n < 60; n++) begin
            @(posedge clk_i);
            if (tx_valid_i && tx_ready_o) rsp.push_back(tx_data_i);
            if (!tx_valid_i && rsp.size() > 0) break;
            tx_ready_o <= (slow == 0) || (n % 3 == 2);
        end
        tx_ready_o <= 1'b0;
    endtask
endmodule // scs_host_model

// >>> tb/scs_command_set_tb.sv
// Bench of the sensor command interpreter: bus tasks plus host frames.
// Assumes scs_host_model and the bound checker are compiled first.
`timescale 1ns/1ns
`include "scs_defines.vh"
module scs_command_set_tb;
    typedef logic [7:0] scs_bq_t[$];
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  ext = 4'h0;
    logic [31:0] rd;
    wire  [31:0] wb_dat_o;
    wire  [7:0]  rx_data, tx_data;
    wire         wb_ack_o, rx_start, rx_valid, rx_err, tx_valid, tx_ready, alert;
    wire         p1_o, p1_oe, p2_o, p2_oe;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc_cnt = 0;
    scs_bq_t     indoor_quality_index = '{8'h00, 8'hFF, 8'h12, 8'h34, 8'hFF, 8'hFF, 8'h04, 8'h56, 8'h07};
    logic [7:0]  md[7] = '{8'h01, 8'h02, 8'h05, 8'h80, 8'h03, 8'h07, 8'h00};
    scs_command_set i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_start_i(rx_start), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
        .rx_err_i(rx_err), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .tx_data_o(tx_data), .sample_alert_o(alert),
        .user_pin_one_i(p1_oe ? p1_o : ext[0]), .user_pin_one_o(p1_o),
        .user_pin_one_oe_o(p1_oe), .user_pin_two_i(p2_oe ? p2_o : ext[1]),
        .user_pin_two_o(p2_o), .user_pin_two_oe_o(p2_oe),
        .user_pin_three_i(ext[2]), .user_pin_four_i(ext[3]));
    scs_host_model i_host (.clk_i(clk_i), .rx_start_o(rx_start), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .rx_err_o(rx_err), .tx_ready_o(tx_ready),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            $display("wrong value at %0t: run timed out", $time);
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        // Only the bench timeout ends a wait that never sees ack
        do @(posedge clk_i); while (!wb_ack_o);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rsp(input scs_bq_t e);
        logic [7:0] s = 8'hFF;
        foreach (e[i]) s -= e[i];
        e.push_back(s);
        chk(i_host.rsp.size(), e.size());
        foreach (e[i]) chk(i_host.rsp[i], e[i]);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        i_host.cmd(8'h10); rsp('{8'h00, 8'h00});
        wb(0, `SCS_ADR_STATUS, 0); chk(rd[23:16], 8'h80);
        i_host.cmd(8'h12, 8'(75 * 255 / 100)); rsp('{8'h00});
        wb(0, `SCS_ADR_STATUS, 0); chk(rd[23:16], 8'hBF);
        wb(1, `SCS_ADR_QUAL, 32'h123);
        wb(1, `SCS_ADR_VOC, 32'h1234);
        wb(1, `SCS_ADR_ETH, 32'h12345);
        wb(1, `SCS_ADR_CO2, 32'h456);
        wb(1, `SCS_ADR_REL, 32'h7);
        foreach (md[i]) begin
            i_host.cmd(8'h11, md[i]); rsp('{8'h00});
            i_host.cmd(8'h10, 8'h00, 0, i % 2); rsp('{8'h00, md[i]});
            i_host.cmd(8'h18);
            if (md[i] inside {8'h01, 8'h02}) rsp(indoor_quality_index);
            else if (md[i] == 8'h05) rsp('{8'h00, 8'h12, 8'h34, 8'hFF, 8'hFF});
            else rsp('{8'h00});
        end
        i_host.cmd(8'h11, 8'h01); rsp('{8'h00});
        wb(1, `SCS_ADR_CTRL, 1);
        wb(1, `SCS_ADR_CTRL, 1);
        // Partial byte lanes: write ignored, so no extra sample
        wb(1, `SCS_ADR_CTRL, 1, 4'h3);
        wb(0, `SCS_ADR_STATUS, 0); chk({rd[24], rd[15:8]}, 9'h102);
        i_host.cmd(8'h18); rsp(indoor_quality_index); chk(alert, 0);
        wb(1, `SCS_ADR_CTRL, 1);
        wb(0, `SCS_ADR_STATUS, 0); chk(alert, 1);
        i_host.cmd(8'h11, 8'h02); rsp('{8'h00}); chk(alert, 0);
        wb(0, `SCS_ADR_STATUS, 0); chk(rd[15:8], 0);
        i_host.cmd(8'h11, 8'h05, 1); rsp('{8'h40});
        i_host.cmd(8'h11, 8'h05, 0, 0, 1); rsp('{8'h80});
        i_host.cmd(8'h10); rsp('{8'h00, 8'h02});
        i_host.cmd(8'h40); rsp('{8'h80});
        ext <= 4'b0100;
        i_host.cmd(8'h20, 8'hFF); rsp('{8'h00}); chk({p2_oe, p1_oe}, 2'b11);
        i_host.cmd(8'h22, 8'hFD); rsp('{8'h00}); chk({p2_o, p1_o}, 2'b01);
        i_host.cmd(8'h22, 8'h02); rsp('{8'h00}); chk({p2_o, p1_o}, 2'b11);
        i_host.cmd(8'h23, 8'hFD); rsp('{8'h00}); chk({p2_o, p1_o}, 2'b10);
        i_host.cmd(8'h21); rsp('{8'h00, 8'h06});
        ext <= 4'b1001;
        i_host.cmd(8'h20, 8'hFC); rsp('{8'h00}); chk({p2_oe, p1_oe}, 2'b00);
        i_host.cmd(8'h21); rsp('{8'h00, 8'h09});
        wb(1, `SCS_ADR_TRK_LO, 32'h44332211);
        wb(1, `SCS_ADR_TRK_HI, 32'h6655);
        i_host.cmd(8'h01, 8'h00, 0, 1);
        rsp('{8'h00, 8'h66, 8'h55, 8'h44, 8'h33, 8'h22, 8'h11});
        wb(0, 8'h30, 0); chk(rd, 0);
        stop_test();
    end
endmodule // scs_command_set_tb
